// File: pid_pkg.sv
/*
 * Constants and types of the display descriptor parser.
 * Assumes a 40 MHz reference clock and a byte-wide descriptor image in local memory.
 */
// Function
// - Byte 12 holds message hold seconds
// - Byte 13 string pointer, MSB first, base zero
// - String bytes 1-2 horizontal offset, zero centres
// - String bytes 3-4 vertical offset, zero centres
// - Following codes are Unicode code points
// - Terminator byte ends the character string
// - Private-use codes carry control meanings
// - Field-gap code recognised inside the string
// - Gap code followed by two-byte column count
// - Graphics code draws an image instead
// - Four bytes give graphic data offset
// - Graphic first two bytes give width
// - Column one byte on glance board, else two
// - Effect field decoded into eight effects
// - Letter size 0-5 selects heights 7-16
// - Regional scripts always use size 16
// - Rows count upward from the bottom
// - Columns count rightward from the left
package pid_pkg;
   // ********************
   // Register offsets.
   // ********************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MADDR  = 8'h08;
   localparam logic [7:0] REG_MDATA  = 8'h0c;
   localparam logic [7:0] REG_ATTR   = 8'h10;
   localparam logic [7:0] REG_TIMING = 8'h14;
   localparam logic [7:0] REG_OFFS   = 8'h18;
   localparam int CTRL_START    = 0;
   localparam int CTRL_REGIONAL = 1;
   localparam int CTRL_GLANCE   = 2;
   // ********************
   // Descriptor layout, byte positions counted from zero.
   // ********************
   localparam logic [31:0] POS_SPEED  = 32'h8;
   localparam logic [31:0] POS_EFFECT = 32'h9;
   localparam logic [31:0] POS_SIZE   = 32'ha;
   localparam logic [31:0] POS_DELAY  = 32'hb;
   localparam logic [31:0] POS_PTR_HI = 32'hc;
   localparam logic [31:0] POS_PTR_LO = 32'hd;
   localparam logic [31:0] POS_TERM1  = 32'he;
   localparam logic [31:0] POS_TERM2  = 32'hf;
   localparam logic [7:0]  TERM_BYTE  = 8'hff;
   localparam logic [15:0] CODE_GAP   = 16'he700;
   localparam logic [15:0] CODE_GFX   = 16'he800;
   localparam logic [15:0] PUA_LO     = 16'he000;
   localparam logic [15:0] PUA_HI     = 16'hf8ff;
   localparam logic [2:0]  SPEED_MAX  = 3'h4;
   localparam logic [3:0]  EFFECT_MAX = 4'h8;
   localparam logic [4:0]  FONT_REGIONAL = 5'h10;
   // ********************
   // Timing.
   // ********************
   localparam int CLK_HZ      = 40000000;
   localparam int HOLD_UNIT_S = 1;
   localparam int CYC_PER_SEC = HOLD_UNIT_S * CLK_HZ;
   // ********************
   // Output items.
   // ********************
   localparam logic [2:0] K_CHAR  = 3'h0;
   localparam logic [2:0] K_CTRL  = 3'h1;
   localparam logic [2:0] K_GAP   = 3'h2;
   localparam logic [2:0] K_GFX_W = 3'h3;
   localparam logic [2:0] K_GFX_C = 3'h4;
   typedef struct packed {
      logic [2:0]  kind;
      logic [15:0] data;
   } pid_item_t;
   typedef struct packed {
      logic [4:0] font_h;
      logic [8:0] effect_oh;
      logic       speed_ok;
      logic       effect_ok;
   } pid_attr_t;
endpackage

// File: pid_attr_dec.sv
/*
 * Lookup of letter height, transition effect and speed validity.
 * Assumes registered descriptor fields on its inputs; purely combinational.
 */
`timescale 1ns/1ps
module pid_attr_dec (
   // Descriptor fields and the regional-script control bit
   input  wire logic [2:0]  size_code,
   input  wire logic [3:0]  effect,
   input  wire logic [2:0]  speed,
   input  wire logic        regional,
   // Decoded attributes
   output pid_pkg::pid_attr_t attr
);
   // ********************
   // Decoding.
   // ********************
   always_comb begin
      attr = '0;
      case (size_code)
         3'h0: attr.font_h = 5'h07;
         3'h1: attr.font_h = 5'h08;
         3'h2: attr.font_h = 5'h0a;
         3'h3: attr.font_h = 5'h0c;
         3'h4: attr.font_h = 5'h0e;
         3'h5: attr.font_h = 5'h10;
         default: attr.font_h = 5'h00;
      endcase
      if (regional) begin
         attr.font_h = pid_pkg::FONT_REGIONAL;
      end
      attr.effect_ok = (effect <= pid_pkg::EFFECT_MAX) && (effect != 4'h0);
      if (attr.effect_ok) begin
         attr.effect_oh = 9'h001 << effect;
      end
      attr.speed_ok = (speed <= pid_pkg::SPEED_MAX);
   end
endmodule

// File: pid_parser.sv
/*
 * Display descriptor parser: loads a descriptor image, walks it and the
 * character string it points at, and emits characters, gaps and graphic columns.
 * Assumes a single-cycle register port master and a renderer that takes items
 * with a valid/ready handshake.
 */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module pid_parser #(
   parameter int MEM_AW     = 10,
   parameter int SEC_CYCLES = pid_pkg::CYC_PER_SEC
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   // Register port
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [31:0]        reg_rdata,
   // Item stream
   output pid_pkg::pid_item_t item,
   output logic               item_valid,
   input  wire logic          item_ready,
   // Message hold
   output logic               msg_expire
);
   // ********************
   // State and storage.
   // ********************
   typedef enum logic [9:0] {
      S_IDLE = 10'h001, S_DESC = 10'h002, S_HDR  = 10'h004, S_CHR  = 10'h008,
      S_GAP  = 10'h010, S_GPTR = 10'h020, S_GW   = 10'h040, S_GCOL = 10'h080,
      S_EMIT = 10'h100, S_HOLD = 10'h200
   } pid_state_t;
   pid_state_t         st;
   pid_state_t         ret_st;
   logic [7:0]         mem [2**MEM_AW];
   logic [MEM_AW-1:0]  wptr;
   logic [31:0]        ptr;
   logic [31:0]        ret_ptr;
   logic [1:0]         cnt;
   logic [23:0]        acc;
   logic [15:0]        gcols;
   logic [7:0]         rd_byte;
   logic [15:0]        code;
   logic               out_range;
   logic               regional;
   logic               glance;
   logic               done;
   logic               err_term;
   logic               err_range;
   logic               start;
   logic               reverse;
   logic [2:0]         speed;
   logic [3:0]         effect;
   logic [2:0]         size_code;
   logic [2:0]         gap;
   logic [7:0]         delay;
   logic [15:0]        str_ptr;
   logic [15:0]        hoff;
   logic [15:0]        voff;
   logic [7:0]         sec_left;
   logic [31:0]        sec_div;
   pid_pkg::pid_attr_t attr;

   assign rd_byte   = mem[ptr[MEM_AW-1:0]];
   assign code      = {acc[7:0], rd_byte};
   assign out_range = (ptr >> MEM_AW) != 32'h0;
   assign start     = reg_wr && (reg_addr == pid_pkg::REG_CTRL)
                      && reg_wdata[pid_pkg::CTRL_START] && (st == S_IDLE);
   assign item_valid = (st == S_EMIT);

   pid_attr_dec u_attr (
      .size_code (size_code),
      .effect    (effect),
      .speed     (speed),
      .regional  (regional),
      .attr      (attr)
   );

   // ********************
   // Register port.
   // ********************
   always_ff @(posedge ref_clk) begin
      if (reg_wr && (reg_addr == pid_pkg::REG_MDATA)) begin
         mem[wptr] <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr     <= '0;
         regional <= 1'b0;
         glance   <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == pid_pkg::REG_CTRL) begin
            regional <= reg_wdata[pid_pkg::CTRL_REGIONAL];
            glance   <= reg_wdata[pid_pkg::CTRL_GLANCE];
         end else if (reg_addr == pid_pkg::REG_MADDR) begin
            wptr <= reg_wdata[MEM_AW-1:0];
         end else if (reg_addr == pid_pkg::REG_MDATA) begin
            wptr <= wptr + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            pid_pkg::REG_CTRL:   reg_rdata <= {29'h0, glance, regional, 1'b0};
            pid_pkg::REG_STATUS: reg_rdata <= {18'h0, st, err_range, err_term,
                                               done, st != S_IDLE};
            pid_pkg::REG_MADDR:  reg_rdata <= 32'(wptr);
            pid_pkg::REG_ATTR:   reg_rdata <= {1'b0, attr, reverse, 1'b0, size_code, gap,
                                               speed, effect};
            pid_pkg::REG_TIMING: reg_rdata <= {8'h0, delay, str_ptr};
            pid_pkg::REG_OFFS:   reg_rdata <= {hoff, voff};
            default:             reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // ********************
   // Descriptor and string header fields.
   // ********************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reverse   <= 1'b0;
         speed     <= 3'h0;
         effect    <= 4'h0;
         size_code <= 3'h0;
         gap       <= 3'h0;
         delay     <= 8'h0;
         str_ptr   <= 16'h0;
         hoff      <= 16'h0;
         voff      <= 16'h0;
      end else if (st == S_DESC) begin
         case (ptr)
            pid_pkg::POS_SPEED: begin
               reverse <= rd_byte[7];
               speed   <= rd_byte[2:0];
            end
            pid_pkg::POS_EFFECT: effect <= rd_byte[3:0];
            pid_pkg::POS_SIZE: begin
               size_code <= rd_byte[5:3];
               gap       <= rd_byte[2:0];
            end
            pid_pkg::POS_DELAY:  delay <= rd_byte;
            pid_pkg::POS_PTR_HI: str_ptr[15:8] <= rd_byte;
            pid_pkg::POS_PTR_LO: str_ptr[7:0] <= rd_byte;
            default: ;
         endcase
      end else if (st == S_HDR) begin
         // Offsets pass through unchanged: row 0 is the bottom, column 0 the left.
         if (cnt == 2'h1) begin
            hoff <= code;
         end
         if (cnt == 2'h3) begin
            voff <= code;
         end
      end
   end

   // ********************
   // Parser sequence.
   // ********************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st        <= S_IDLE;
         ret_st    <= S_IDLE;
         ptr       <= 32'h0;
         ret_ptr   <= 32'h0;
         cnt       <= 2'h0;
         acc       <= 24'h0;
         gcols     <= 16'h0;
         item      <= '0;
         done      <= 1'b0;
         err_term  <= 1'b0;
         err_range <= 1'b0;
      end else begin
         if (!(st inside {S_IDLE, S_EMIT, S_HOLD})) begin
            ptr <= ptr + 32'h1;
            cnt <= cnt + 2'h1;
            acc <= {acc[15:0], rd_byte};
            if (out_range) begin
               err_range <= 1'b1;
               st        <= S_IDLE;
            end
         end
         if (!(st inside {S_IDLE, S_EMIT, S_HOLD}) && !out_range) begin
            case (st)
               S_DESC: begin
                  if ((ptr >= pid_pkg::POS_TERM1) && (rd_byte != pid_pkg::TERM_BYTE)) begin
                     err_term <= 1'b1;
                     st       <= S_IDLE;
                  end else if (ptr == pid_pkg::POS_TERM2) begin
                     ptr <= {16'h0, str_ptr};
                     cnt <= 2'h0;
                     st  <= S_HDR;
                  end
               end
               S_HDR: begin
                  if (cnt == 2'h3) begin
                     cnt <= 2'h0;
                     st  <= S_CHR;
                  end
               end
               S_CHR: begin
                  if (cnt == 2'h0 && rd_byte == pid_pkg::TERM_BYTE) begin
                     done <= 1'b1;
                     st   <= S_HOLD;
                  end else if (cnt == 2'h1) begin
                     cnt <= 2'h0;
                     if (code == pid_pkg::CODE_GAP) begin
                        st <= S_GAP;
                     end else if (code == pid_pkg::CODE_GFX) begin
                        st <= S_GPTR;
                     end else begin
                        item.data <= code;
                        item.kind <= (code >= pid_pkg::PUA_LO && code <= pid_pkg::PUA_HI) ?
                                     pid_pkg::K_CTRL : pid_pkg::K_CHAR;
                        ret_st <= S_CHR;
                        st     <= S_EMIT;
                     end
                  end
               end
               S_GAP: begin
                  if (cnt == 2'h1) begin
                     item   <= '{kind: pid_pkg::K_GAP, data: code};
                     cnt    <= 2'h0;
                     ret_st <= S_CHR;
                     st     <= S_EMIT;
                  end
               end
               S_GPTR: begin
                  if (cnt == 2'h3) begin
                     ret_ptr <= ptr + 32'h1;
                     ptr     <= {acc, rd_byte};
                     cnt     <= 2'h0;
                     st      <= S_GW;
                  end
               end
               S_GW: begin
                  if (cnt == 2'h1) begin
                     gcols <= code;
                     cnt   <= 2'h0;
                     item  <= '{kind: pid_pkg::K_GFX_W, data: code};
                     if (code == 16'h0) begin
                        ptr    <= ret_ptr;
                        ret_st <= S_CHR;
                     end else begin
                        ret_st <= S_GCOL;
                     end
                     st <= S_EMIT;
                  end
               end
               S_GCOL: begin
                  if (glance || cnt == 2'h1) begin
                     item.kind <= pid_pkg::K_GFX_C;
                     item.data <= glance ? {8'h0, rd_byte} : code;
                     gcols     <= gcols - 16'h1;
                     cnt       <= 2'h0;
                     st        <= S_EMIT;
                     if (gcols == 16'h1) begin
                        ptr    <= ret_ptr;
                        ret_st <= S_CHR;
                     end else begin
                        ret_st <= S_GCOL;
                     end
                  end
               end
               default: ;
            endcase
         end
         case (st)
            S_IDLE: begin
               if (start) begin
                  ptr       <= 32'h0;
                  cnt       <= 2'h0;
                  done      <= 1'b0;
                  err_term  <= 1'b0;
                  err_range <= 1'b0;
                  st        <= S_DESC;
               end
            end
            S_EMIT: begin
               if (item_ready) begin
                  st <= ret_st;
               end
            end
            S_HOLD: begin
               if (sec_left == 8'h0) begin
                  st <= S_IDLE;
               end
            end
            default: ;
         endcase
      end
   end

   // ********************
   // Message hold timer.
   // ********************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_div    <= 32'h0;
         sec_left   <= 8'h0;
         msg_expire <= 1'b0;
      end else begin
         msg_expire <= (st == S_HOLD) && (sec_left == 8'h0);
         if (st != S_HOLD) begin
            sec_div  <= 32'h0;
            sec_left <= delay;
         end else if (sec_div == 32'(SEC_CYCLES - 1)) begin
            sec_div  <= 32'h0;
            sec_left <= sec_left - 8'h1;
         end else begin
            sec_div <= sec_div + 32'h1;
         end
      end
   end

   // ********************
   // Assertions.
   // ********************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_hold_end;
      (st == S_HOLD && sec_left == 8'h0) |=> (st == S_IDLE) && msg_expire;
   endproperty
   a_hold_end: assert property (p_hold_end) else $error("hold did not end");

   property p_str_jump;
      (st == S_DESC && ptr == pid_pkg::POS_TERM2 && rd_byte == pid_pkg::TERM_BYTE)
      |=> (st == S_HDR) && (ptr == {16'h0, str_ptr});
   endproperty
   a_str_jump: assert property (p_str_jump) else $error("string pointer not used");

   property p_hoff;
      (st == S_HDR && cnt == 2'h1) |=> hoff == {$past(acc[7:0]), $past(rd_byte)};
   endproperty
   a_hoff: assert property (p_hoff) else $error("horizontal offset wrong");

   property p_voff;
      (st == S_HDR && cnt == 2'h3 && !out_range) |=> (voff == $past(code)) && (st == S_CHR);
   endproperty
   a_voff: assert property (p_voff) else $error("vertical offset wrong");

   property p_term;
      (st == S_CHR && cnt == 2'h0 && rd_byte == pid_pkg::TERM_BYTE && !out_range)
      |=> done && (st == S_HOLD);
   endproperty
   a_term: assert property (p_term) else $error("terminator missed");

   property p_gap;
      (st == S_CHR && cnt == 2'h1 && code == pid_pkg::CODE_GAP && !out_range)
      |=> (st == S_GAP) ##2 (item_valid && item.kind == pid_pkg::K_GAP);
   endproperty
   a_gap: assert property (p_gap) else $error("gap code not handled");

   property p_gfx;
      (st == S_CHR && cnt == 2'h1 && code == pid_pkg::CODE_GFX && !out_range)
      |=> (st == S_GPTR) [*4];
   endproperty
   a_gfx: assert property (p_gfx) else $error("graphics code not handled");

   property p_col;
      (st == S_GCOL && glance && !out_range)
      |=> item_valid && item.kind == pid_pkg::K_GFX_C && item.data[15:8] == 8'h0;
   endproperty
   a_col: assert property (p_col) else $error("glance column not one byte");

   property p_bad_term;
      (st == S_DESC && ptr >= pid_pkg::POS_TERM1 && rd_byte != pid_pkg::TERM_BYTE)
      |=> err_term && (st == S_IDLE);
   endproperty
   a_bad_term: assert property (p_bad_term) else $error("bad descriptor end accepted");

   c_char: cover property (item_valid && item_ready && item.kind == pid_pkg::K_CHAR);
   c_gfx: cover property (item_valid && item.kind == pid_pkg::K_GFX_C);
   c_expire: cover property (msg_expire);
endmodule

// File: pid_sink.sv
/*
 * Renderer model for the parser's item stream: records every item taken.
 * Assumes the valid/ready handshake on ref_clk; slow stalls ready three cycles in four.
 */
`timescale 1ns/1ps
module pid_sink (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   // Item stream
   input  wire pid_pkg::pid_item_t item,
   input  wire logic               item_valid,
   output logic                    item_ready,
   // Stall control and hold errors
   input  wire logic               slow,
   output int                      n_bad
);
   pid_pkg::pid_item_t got [$];
   pid_pkg::pid_item_t last;
   logic [1:0]         ph;
   logic               wait_q;

   assign item_ready = slow ? (ph == 2'h3) : 1'b1;

   // An offered item must stand unchanged until it is taken.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 2'h0;
         wait_q <= 1'b0;
         n_bad <= 0;
      end else begin
         ph <= ph + 2'h1;
         wait_q <= item_valid && !item_ready;
         last <= item;
         if (wait_q && (item_valid !== 1'b1 || item !== last)) begin
            n_bad <= n_bad + 1;
         end
         if (item_valid === 1'b1 && item_ready) begin
            got.push_back(item);
         end
      end
   end
endmodule

// File: test_pid_parser.sv
/*
 * Self-checking bench for the descriptor parser.
 * Assumes pid_sink as the renderer and a short second (SEC_CYCLES of 10).
 */
`timescale 1ns/1ps
module test_pid_parser;
   typedef struct packed {
      logic [2:0] sz;
      logic [2:0] gp;
      logic [3:0] ef;
      logic [2:0] sp;
      logic       rg;
      logic [4:0] fh;
      logic       eok;
      logic       sok;
   } pid_row_t;
   logic               ref_clk = 1'b0;
   logic               rst_n = 1'b0;
   logic [7:0]         reg_addr = 8'h00;
   logic [31:0]        reg_wdata = 32'h0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic               slow = 1'b0;
   logic [31:0]        reg_rdata;
   pid_pkg::pid_item_t item;
   logic               item_valid;
   logic               item_ready;
   logic               msg_expire;
   int                 n_bad;
   int                 n_fail = 0;
   int                 checked = 0;
   int                 cyc = 0;
   int                 t_exp = -1;
   int                 t_start;
   int                 t_done;
   int                 p;
   logic [7:0]         img [0:127];
   logic [31:0]        s;
   logic [15:0]        hoff;
   logic [15:0]        voff;
   logic [15:0]        code;
   pid_row_t           r;
   pid_pkg::pid_item_t exp_q [$];
   pid_row_t rows [10] = '{'{0,7,0,0,0,7,0,1}, '{1,6,1,1,0,8,1,1}, '{2,5,2,2,0,10,1,1},
      '{3,4,3,3,0,12,1,1}, '{4,3,4,4,0,14,1,1}, '{5,2,5,5,0,16,1,0}, '{6,1,6,6,0,0,1,0},
      '{7,0,7,7,0,0,1,0}, '{0,1,8,0,1,16,1,1}, '{2,0,9,1,1,16,0,1}};
   logic [7:0] str [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'he7, 8'h00, 8'h00, 8'h05, 8'he1,
      8'h23, 8'he8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h41, 8'hff};

   always #12.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      cyc++;
      if (msg_expire === 1'b1) begin
         t_exp = cyc;
      end
   end

   pid_parser #(.MEM_AW(10), .SEC_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .item(item), .item_valid(item_valid), .item_ready(item_ready),
      .msg_expire(msg_expire));
   pid_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .item(item), .item_valid(item_valid),
      .item_ready(item_ready), .slow(slow), .n_bad(n_bad));

   // ****************************************
   // Register port and compare tasks.
   // ****************************************
   task automatic tally_and_finish();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] ex, input logic [31:0] m);
      checked++;
      if ((got & m) !== (ex & m)) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic cmp_items();
      checked++;
      if (sink.got.size() != exp_q.size() || n_bad != 0) begin
         n_fail++;
         $display("ERROR %0t: item count %0d or hold fault", $time, sink.got.size());
      end
      foreach (exp_q[k]) begin
         cmp({13'h0, sink.got[k]}, {13'h0, exp_q[k]}, 32'h7ffff);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   // ****************************************
   // Image building and parse runs.
   // ****************************************
   task automatic desc(input logic [7:0] b8, b9, b10, b11, input logic [15:0] ptr);
      for (int k = 0; k < 8; k++) begin
         img[k] = k[7:0];
      end
      img[8] = b8;
      img[9] = b9;
      img[10] = b10;
      img[11] = b11;
      img[12] = ptr[15:8];
      img[13] = ptr[7:0];
      img[14] = 8'hff;
      img[15] = 8'hff;
   endtask
   task automatic run(input int n, input logic [2:0] ctl);
      int k;
      wr(pid_pkg::REG_MADDR, 32'h0);
      for (k = 0; k < n; k++) begin
         wr(pid_pkg::REG_MDATA, {24'h0, img[k]});
      end
      sink.got.delete();
      wr(pid_pkg::REG_CTRL, {29'h0, ctl});
      t_start = cyc;
      s = 32'h1;
      k = 0;
      while (s[0] && !s[1] && k < 300) begin
         rd(pid_pkg::REG_STATUS, s);
         k++;
      end
      t_done = cyc;
      if (k == 300) begin
         n_fail++;
         $display("ERROR %0t: parse timeout", $time);
         tally_and_finish();
      end
   endtask
   task automatic hold(input int d);
      int c;
      c = 0;
      while (t_exp <= t_start && c < 200) begin
         @(negedge ref_clk);
         c++;
      end
      if (c == 200) begin
         n_fail++;
         $display("ERROR %0t: hold timeout", $time);
         tally_and_finish();
      end
      cmp({31'h0, (t_exp - t_done) inside {[d * 10 - 3 : d * 10 + 3]}}, 32'h1, 32'h1);
      rd(pid_pkg::REG_STATUS, s);
      cmp(s, 32'h10, 32'h3ff1);
   endtask

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      repeat (3) @(posedge ref_clk);
      cmp({reg_rdata[31:2], item_valid, msg_expire}, 32'h0, 32'hffffffff);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(pid_pkg::REG_STATUS, s);
      cmp(s, 32'h10, 32'h3fff);
      rd(8'h1c, s);
      cmp(s, 32'h0, 32'hffffffff);
      $display("reset test done");
      foreach (rows[i]) begin
         r = rows[i];
         p = 16 + i;
         desc({i[0], 4'h0, r.sp}, {4'h0, r.ef}, {2'b10, r.sz, r.gp}, i[7:0], p[15:0]);
         hoff = (i == 0) ? 16'h0 : 16'h0100 + i[15:0];
         voff = (i == 1) ? 16'h0 : 16'h0200 + i[15:0];
         code = r.rg ? 16'h0900 + i[15:0] : 16'h0041 + i[15:0];
         {img[p], img[p+1], img[p+2], img[p+3], img[p+4], img[p+5]} = {hoff, voff, code};
         img[p+6] = 8'hff;
         exp_q = '{'{pid_pkg::K_CHAR, code}};
         run(p + 7, {1'b0, r.rg, 1'b1});
         cmp(s, 32'h2, 32'he);
         rd(pid_pkg::REG_ATTR, s);
         cmp(s, {1'b0, r.fh, r.eok ? 9'h1 << r.ef : 9'h0, r.sok, r.eok, i[0], 1'b0, r.sz, r.gp,
            r.sp, r.ef}, 32'hffffffff);
         rd(pid_pkg::REG_TIMING, s);
         cmp(s, {8'h0, i[7:0], p[15:0]}, 32'hffffffff);
         rd(pid_pkg::REG_OFFS, s);
         cmp(s, {hoff, voff}, 32'hffffffff);
         hold(i);
         cmp_items();
         $display("row %0d done", i);
      end
      slow <= 1'b1;
      for (int g = 0; g < 2; g++) begin
         desc(8'h00, 8'h01, 8'h00, 8'h00, 16'h0010);
         foreach (str[k]) begin
            img[16 + k] = str[k];
         end
         {img[48], img[49], img[50], img[51], img[52], img[53]} = 48'h0002_a1b2_c3d4;
         exp_q = '{'{pid_pkg::K_GAP, 16'h0005}, '{pid_pkg::K_CTRL, 16'he123},
            '{pid_pkg::K_GFX_W, 16'h0002}, '{pid_pkg::K_GFX_C, g ? 16'h00a1 : 16'ha1b2},
            '{pid_pkg::K_GFX_C, g ? 16'h00b2 : 16'hc3d4}, '{pid_pkg::K_CHAR, 16'h0041}};
         run(54, {g[0], 2'b01});
         hold(0);
         cmp_items();
         $display("graphic test %0d done", g);
      end
      slow <= 1'b0;
      desc(8'h00, 8'h01, 8'h00, 8'h00, 16'h0010);
      img[15] = 8'h00;
      run(16, 3'h1);
      cmp(s, 32'h14, 32'h3ffd);
      desc(8'h00, 8'h01, 8'h00, 8'h00, 16'hff00);
      run(16, 3'h1);
      cmp(s, 32'h18, 32'h3ffd);
      $display("error tests done");
      tally_and_finish();
   end
endmodule
